/* File: ser_status.sv */
/*
 * Status-event reporting: common command parser, event status register,
 * 16-bit event enable mask and the summary bit of the status byte.
 * Assumes bytes arrive already decoded from the bus, one per valid cycle.
 */
`timescale 1ns/10ps
module ser_status (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Command byte stream
    input ser_pkg::ser_byte_type cmd_in,
    output logic cmd_ready,
    // Response byte stream
    output ser_pkg::ser_byte_type rsp_out,
    input wire logic rsp_ready,
    // Event sources: one-cycle error pulses and the operations-pending level
    input wire logic ev_dev_err,
    input wire logic ev_exe_err,
    input wire logic ops_pending,
    // Status and forwarded commands
    output logic [7:0] status_byte,
    output logic [7:0] event_status,
    output logic [15:0] event_enable_mask,
    output logic err_queue_clear,
    output logic [3:0] other_cmd,
    output logic other_cmd_stb,
    output logic sub_hdr_stb,
    output logic [3:0] sub_level
);
    logic rst_s1, rst_n;
    ser_pkg::ser_state_type state;
    logic is_common, is_query, parm_seen, parm_bad, hdr_bad;
    logic [1:0] radix;
    logic [3:0] hlen;
    logic [7:0] hdr [ser_pkg::HDR_MAX];
    logic [15:0] parm;
    ser_pkg::ser_cmd_type cmd;
    logic opc_watch, acted;
    logic fmt_start, fmt_busy;
    logic [15:0] fmt_val;
    logic [7:0] c, cu;
    logic [3:0] digit;
    logic digit_ok;
    logic take;
    logic set_cme, set_qye;

    // ==========================================================
    // Reset release
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // ==========================================================
    // Character classification
    assign c = cmd_in.data;
    assign cu = (c >= 8'h61) ? (c & ~ser_pkg::CH_CASE) : c;
    always_comb begin
        digit = 4'h0;
        digit_ok = 1'b0;
        if (c >= ser_pkg::CH_ZERO && c <= ser_pkg::CH_NINE) begin
            digit = 4'(c - ser_pkg::CH_ZERO);
            digit_ok = (radix == 2'd2) ? (digit < 4'd8) : (radix == 2'd1) ? (digit < 4'd2) : 1'b1;
        end else if (radix == 2'd3 && cu >= ser_pkg::CH_UA && cu <= 8'h46) begin
            digit = 4'(cu - ser_pkg::CH_UA + 8'd10);
            digit_ok = 1'b1;
        end
    end

    assign cmd_ready = (state == ser_pkg::ST_IDLE) || (state == ser_pkg::ST_HDR)
                       || (state == ser_pkg::ST_PARM) || (state == ser_pkg::ST_SKIP);
    assign take = cmd_in.valid && cmd_ready;

    // ==========================================================
    // Header matcher; only three-letter common headers decode, other lengths are bad
    function automatic ser_pkg::ser_cmd_type match(input logic [3:0] n, input logic q,
                                                   input logic [7:0] a, input logic [7:0] b,
                                                   input logic [7:0] d);
        logic [23:0] w;
        w = {a, b, d};
        match = ser_pkg::CMD_BAD;
        if (n == 4'd3) begin
            case (w)
                24'h43_4C53: match = q ? ser_pkg::CMD_BAD : ser_pkg::CMD_CLS;
                24'h45_5345: match = q ? ser_pkg::CMD_ESEQ : ser_pkg::CMD_ESE;
                24'h45_5352: match = q ? ser_pkg::CMD_ESRQ : ser_pkg::CMD_BAD;
                24'h4F_5043: match = q ? ser_pkg::CMD_OTHER : ser_pkg::CMD_OPC;
                24'h49_444E, 24'h53_5442, 24'h54_5354:
                    match = q ? ser_pkg::CMD_OTHER : ser_pkg::CMD_BAD;
                24'h52_5354, 24'h57_4149: match = q ? ser_pkg::CMD_BAD : ser_pkg::CMD_OTHER;
                24'h53_5245: match = ser_pkg::CMD_OTHER;
                default: match = ser_pkg::CMD_BAD;
            endcase
        end
    endfunction

    // ==========================================================
    // Parser state machine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ser_pkg::ST_IDLE;
            is_common <= 1'b0;
            is_query <= 1'b0;
            hlen <= 4'h0;
            parm <= 16'h0000;
            parm_seen <= 1'b0;
            parm_bad <= 1'b0;
            hdr_bad <= 1'b0;
            radix <= 2'd0;
            sub_level <= 4'h0;
            cmd <= ser_pkg::CMD_NONE;
            acted <= 1'b0;
            for (int i = 0; i < ser_pkg::HDR_MAX; i++) hdr[i] <= 8'h00;
        end else begin
            case (state)
                ser_pkg::ST_IDLE: if (take && c != ser_pkg::CH_NL && c != ser_pkg::CH_SPACE) begin
                    is_common <= (c == ser_pkg::CH_STAR);
                    is_query <= 1'b0;
                    hlen <= 4'h0;
                    parm <= 16'h0000;
                    parm_seen <= 1'b0;
                    parm_bad <= 1'b0;
                    hdr_bad <= 1'b0;
                    radix <= 2'd0;
                    sub_level <= 4'h1;
                    if (c != ser_pkg::CH_STAR && c != ser_pkg::CH_COLON) begin
                        hdr[0] <= cu;
                        hlen <= 4'h1;
                    end
                    state <= (cmd_in.last) ? ser_pkg::ST_EXEC : ser_pkg::ST_HDR;
                end
                ser_pkg::ST_HDR: if (take) begin
                    if (c == ser_pkg::CH_NL || c == ser_pkg::CH_SEMI || cmd_in.last)
                        state <= ser_pkg::ST_EXEC;
                    else if (c == ser_pkg::CH_SPACE)
                        state <= ser_pkg::ST_PARM;
                    else if (c == ser_pkg::CH_QUERY)
                        is_query <= 1'b1;
                    else if (c == ser_pkg::CH_COLON && !is_common) begin
                        sub_level <= sub_level + 4'h1;
                        hlen <= 4'h0;
                    end else if (hlen < 4'(ser_pkg::HDR_MAX)) begin
                        hdr[hlen] <= cu;
                        hlen <= hlen + 4'h1;
                    end else
                        hdr_bad <= 1'b1;
                end
                ser_pkg::ST_PARM: if (take) begin
                    if (c == ser_pkg::CH_NL || c == ser_pkg::CH_SEMI || cmd_in.last)
                        state <= ser_pkg::ST_EXEC;
                    else if (c == ser_pkg::CH_HASH)
                        radix <= 2'd0;
                    else if (!parm_seen && radix == 2'd0 && (cu == ser_pkg::CH_B
                             || cu == ser_pkg::CH_Q || cu == ser_pkg::CH_H)) begin
                        radix <= (cu == ser_pkg::CH_B) ? 2'd1 : (cu == ser_pkg::CH_Q) ? 2'd2
                                 : 2'd3;
                    end else if (digit_ok) begin
                        parm_seen <= 1'b1;
                        case (radix)
                            2'd1: parm <= {parm[14:0], digit[0]};
                            2'd2: parm <= {parm[12:0], digit[2:0]};
                            2'd3: parm <= {parm[11:0], digit};
                            default: parm <= 16'(parm * 16'd10 + {12'h000, digit});
                        endcase
                    end else if (c != ser_pkg::CH_SPACE)
                        parm_bad <= 1'b1;
                end
                ser_pkg::ST_EXEC: begin
                    cmd <= !is_common ? ser_pkg::CMD_SUB : hdr_bad ? ser_pkg::CMD_BAD
                           : match(hlen, is_query, hdr[0], hdr[1], hdr[2]);
                    acted <= 1'b0;
                    state <= ser_pkg::ST_REPLY;
                end
                ser_pkg::ST_REPLY: begin
                    acted <= 1'b1;
                    if (!fmt_busy && !fmt_start) begin
                        cmd <= ser_pkg::CMD_NONE;
                        state <= ser_pkg::ST_IDLE;
                    end
                end
                default: state <= ser_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Command execution strobes
    logic in_reply, ese_ok;
    assign in_reply = (state == ser_pkg::ST_REPLY) && !acted;
    assign ese_ok = parm_seen && !parm_bad;
    assign set_cme = in_reply && (cmd == ser_pkg::CMD_BAD
                     || (cmd == ser_pkg::CMD_ESE && !ese_ok));
    assign set_qye = 1'b0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            other_cmd <= 4'h0;
            other_cmd_stb <= 1'b0;
            sub_hdr_stb <= 1'b0;
            err_queue_clear <= 1'b0;
        end else begin
            other_cmd_stb <= in_reply && cmd == ser_pkg::CMD_OTHER;
            other_cmd <= hlen;
            sub_hdr_stb <= in_reply && cmd == ser_pkg::CMD_SUB;
            err_queue_clear <= in_reply && cmd == ser_pkg::CMD_CLS;
        end
    end

    // Enable mask; clear-status does not touch it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            event_enable_mask <= ser_pkg::MASK_RST;
        else if (in_reply && cmd == ser_pkg::CMD_ESE && ese_ok)
            event_enable_mask <= parm;
    end

    // Operation-complete watch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            opc_watch <= 1'b0;
        else if (in_reply && cmd == ser_pkg::CMD_CLS)
            opc_watch <= 1'b0;
        else if (in_reply && cmd == ser_pkg::CMD_OPC)
            opc_watch <= 1'b1;
    end

    // Event status register; a new event beats a simultaneous clear
    logic [7:0] ev_set;
    always_comb begin
        ev_set = 8'h00;
        ev_set[ser_pkg::EV_OPC] = opc_watch && !ops_pending;
        ev_set[ser_pkg::EV_QYE] = set_qye;
        ev_set[ser_pkg::EV_DDE] = ev_dev_err;
        ev_set[ser_pkg::EV_EXE] = ev_exe_err;
        ev_set[ser_pkg::EV_CME] = set_cme;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            event_status <= ser_pkg::EV_RST;
        else if (in_reply && cmd == ser_pkg::CMD_CLS)
            event_status <= ev_set & ser_pkg::EV_USED;
        else if (in_reply && cmd == ser_pkg::CMD_ESRQ)
            event_status <= ev_set & ser_pkg::EV_USED; // Read clears
        else
            event_status <= (event_status | ev_set) & ser_pkg::EV_USED;
    end

    // Only the summary bit is kept here; other status byte bits are outside
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            status_byte <= 8'h00;
        else begin
            status_byte <= 8'h00;
            status_byte[ser_pkg::STB_ESB] <= |(event_status & event_enable_mask[7:0]);
        end
    end

    // ==========================================================
    // Query replies
    assign fmt_start = in_reply && (cmd == ser_pkg::CMD_ESEQ || cmd == ser_pkg::CMD_ESRQ);
    assign fmt_val = (cmd == ser_pkg::CMD_ESEQ) ? event_enable_mask
                     : {8'h00, event_status};

    ser_dec_out u_fmt (
        .clk(clk),
        .rst_n(rst_n),
        .start(fmt_start),
        .value(fmt_val),
        .busy(fmt_busy),
        .out_byte(rsp_out),
        .out_ready(rsp_ready)
    );
endmodule // ser_status

/* File: ser_pkg.sv */
/*
 * Package for the status-event reporting block: characters, field positions,
 * event bit positions, reset values and state encodings.
 * Assumes a byte-serial command stream from the bus interface logic.
 */
package ser_pkg;
    // ==========================================================
    // Characters
    localparam logic [7:0] CH_STAR = 8'h2A;
    localparam logic [7:0] CH_COLON = 8'h3A;
    localparam logic [7:0] CH_QUERY = 8'h3F;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_NL = 8'h0A;
    localparam logic [7:0] CH_SEMI = 8'h3B;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_UA = 8'h41;
    localparam logic [7:0] CH_CASE = 8'h20;
    localparam logic [7:0] CH_B = 8'h42;
    localparam logic [7:0] CH_Q = 8'h51;
    localparam logic [7:0] CH_H = 8'h48;
    // ==========================================================
    // Event register bits
    localparam int EV_OPC = 0;
    localparam int EV_QYE = 2;
    localparam int EV_DDE = 3;
    localparam int EV_EXE = 4;
    localparam int EV_CME = 5;
    localparam int EV_PON = 7;
    localparam logic [7:0] EV_USED = 8'hBD;
    localparam int STB_ESB = 5;
    localparam int MASK_W = 16;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [7:0] EV_RST = 8'h80;
    localparam int HDR_MAX = 12;
    // ==========================================================
    // Common command codes
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0, CMD_CLS = 4'h1, CMD_ESE = 4'h2, CMD_ESEQ = 4'h3,
        CMD_ESRQ = 4'h4, CMD_OPC = 4'h5, CMD_BAD = 4'h6, CMD_SUB = 4'h7,
        CMD_OTHER = 4'h8
    } ser_cmd_type;
    // ==========================================================
    // Parser states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_HDR = 6'b000010,
        ST_PARM = 6'b000100,
        ST_SKIP = 6'b001000,
        ST_EXEC = 6'b010000,
        ST_REPLY = 6'b100000
    } ser_state_type;
    // ==========================================================
    // Byte stream carrier
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } ser_byte_type;
endpackage

/* File: ser_dec_out.sv */
/*
 * Decimal formatter: turns a 16-bit value into ASCII digits, newline and
 * end indication. Assumes the sink takes one byte per ready cycle.
 */
`timescale 1ns/10ps
module ser_dec_out (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request
    input wire logic start,
    input wire logic [15:0] value,
    output logic busy,
    // Byte output
    output ser_pkg::ser_byte_type out_byte,
    input wire logic out_ready
);
    logic [3:0] dig [5];
    logic [2:0] cnt;
    logic [2:0] idx;
    logic [15:0] rem;
    logic conv;
    logic sending;
    logic load;
    logic [3:0] next_dig;
    logic [15:0] next_rem;

    // ==========================================================
    // Repeated division by ten, one digit per cycle
    always_comb begin
        next_dig = 4'(rem % 16'd10);
        next_rem = rem / 16'd10;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rem <= 16'h0000;
            cnt <= 3'h0;
            conv <= 1'b0;
            sending <= 1'b0;
            idx <= 3'h0;
            for (int i = 0; i < 5; i++) dig[i] <= 4'h0;
        end else if (start && !busy) begin
            rem <= value;
            cnt <= 3'h0;
            conv <= 1'b1;
        end else if (conv) begin
            dig[cnt] <= next_dig;
            rem <= next_rem;
            cnt <= cnt + 3'h1;
            if (next_rem == 16'h0000) begin
                conv <= 1'b0;
                sending <= 1'b1;
                idx <= cnt + 3'h1;
            end
        end else if (load) begin
            if (idx == 3'h0) sending <= 1'b0;
            else idx <= idx - 3'h1;
        end
    end

    // Index steps only when a byte is loaded, so a stalled sink never sees a repeat
    assign load = sending && !(out_byte.valid && !out_ready);
    assign busy = conv | sending;

    // Most significant digit first, then newline flagged last
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_byte <= '0;
        end else if (load) begin
            out_byte.valid <= 1'b1;
            out_byte.last <= (idx == 3'h0);
            out_byte.data <= (idx == 3'h0) ? ser_pkg::CH_NL
                                           : (ser_pkg::CH_ZERO | {4'h0, dig[idx - 3'h1]});
        end else if (out_ready) begin
            out_byte <= '0;
        end
    end
endmodule // ser_dec_out

/* File: ser_status_chk.sv */
/*
 * Checker for the status-event block: concurrent properties on its ports.
 * Assumes it is bound to ser_status and shares its clock and reset.
 */
`timescale 1ns/10ps
module ser_status_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Observed ports
    input wire logic ev_dev_err,
    input wire logic ev_exe_err,
    input wire logic rsp_ready,
    input wire ser_pkg::ser_byte_type rsp_out,
    input wire logic [7:0] status_byte,
    input wire logic [7:0] event_status,
    input wire logic [15:0] event_enable_mask,
    input wire logic err_queue_clear,
    input wire logic sub_hdr_stb
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // Properties
    summary_bit_a: assert property (
        status_byte[5] == |($past(event_status) & $past(event_enable_mask[7:0])))
        else $error("summary bit differs from masked events");
    unused_bits_a: assert property (!event_status[1] && !event_status[6])
        else $error("unused event bits set");
    clear_events_a: assert property (
        err_queue_clear |-> ##[0:2] (event_status == 8'h00 && status_byte == 8'h00))
        else $error("clear-status left events standing");
    mask_kept_a: assert property (err_queue_clear |-> $stable(event_enable_mask))
        else $error("clear-status changed the mask");
    clear_pulse_a: assert property (err_queue_clear |=> !err_queue_clear)
        else $error("error queue clear longer than one cycle");
    sub_pulse_a: assert property (sub_hdr_stb |=> !sub_hdr_stb)
        else $error("subsystem strobe longer than one cycle");
    dev_event_a: assert property (ev_dev_err |-> ##[1:2] event_status[3])
        else $error("device error not recorded");
    exe_event_a: assert property (ev_exe_err |-> ##[1:2] event_status[4])
        else $error("execution error not recorded");
    reply_hold_a: assert property (rsp_out.valid && !rsp_ready |=> $stable(rsp_out))
        else $error("reply byte changed while stalled");
    reply_end_a: assert property (rsp_out.valid && rsp_out.last |-> rsp_out.data == 8'h0A)
        else $error("end indication not on newline");
endmodule // ser_status_chk

bind ser_status ser_status_chk u_ser_status_chk (
    .clk(clk), .arst_n(arst_n), .ev_dev_err(ev_dev_err), .ev_exe_err(ev_exe_err),
    .rsp_ready(rsp_ready), .rsp_out(rsp_out), .status_byte(status_byte),
    .event_status(event_status), .event_enable_mask(event_enable_mask),
    .err_queue_clear(err_queue_clear), .sub_hdr_stb(sub_hdr_stb)
);

/* File: ser_host_model.sv */
/*
 * Bus controller model: sends command messages byte by byte, takes replies.
 * Assumes the testbench calls send at a rising edge of the shared clock.
 */
`timescale 1ns/10ps
module ser_host_model (
    // Clock
    input wire logic clk,
    // Command side
    output ser_pkg::ser_byte_type cmd_in,
    input wire logic cmd_ready,
    // Reply side
    input wire ser_pkg::ser_byte_type rsp_out,
    output logic rsp_ready
);
    logic slow = 1'b0;
    logic [7:0] rq[$];
    int last_cnt = 0;
    initial begin
        cmd_in = '0;
        rsp_ready = 1'b1;
    end
    // ==========================================================
    // Reply sink; slow mode stalls every other cycle
    always @(posedge clk) begin
        rsp_ready <= slow ? ~rsp_ready : 1'b1;
        if (rsp_out.valid && rsp_ready) begin
            rq.push_back(rsp_out.data);
            if (rsp_out.last) last_cnt++;
        end
    end
    // ==========================================================
    // Message sender; byte held until taken, data scrambled when idle
    task automatic send(input string s, output bit ok);
        int w;
        ok = 1'b1;
        for (int i = 0; i < s.len(); i++) begin
            cmd_in <= {1'b1, i == s.len() - 1, s[i]};
            @(negedge clk);
            for (w = 0; w < 300 && !cmd_ready; w++) @(negedge clk);
            if (!cmd_ready) ok = 1'b0;
            @(posedge clk);
        end
        cmd_in <= {2'b00, ~cmd_in.data};
    endtask
endmodule // ser_host_model

/* File: tb_top.sv */
/*
 * Testbench for ser_status: drives command messages through the host model.
 * Assumes ser_pkg, ser_status and its checker are compiled before it.
 */
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ev_dev_err = 1'b0;
    logic ev_exe_err = 1'b0;
    logic ops_pending = 1'b0;
    ser_pkg::ser_byte_type cmd_in, rsp_out;
    logic cmd_ready, rsp_ready, err_queue_clear, other_cmd_stb, sub_hdr_stb;
    logic [7:0] status_byte, event_status;
    logic [15:0] event_enable_mask;
    logic [3:0] other_cmd, sub_level, lvl;
    int mismatches = 0;
    int cmp_count = 0;
    int clr_cnt = 0;
    int oth_cnt = 0;
    int sub_cnt = 0;
    string forms[4] = '{"*ESE 32\n", "*ESE #B100000\n", "*ESE #Q40\n", "*ESE #H20\n"};
    always #25 clk = ~clk;
    ser_status u_ser_status (.clk(clk), .arst_n(arst_n), .cmd_in(cmd_in),
        .cmd_ready(cmd_ready), .rsp_out(rsp_out), .rsp_ready(rsp_ready),
        .ev_dev_err(ev_dev_err), .ev_exe_err(ev_exe_err), .ops_pending(ops_pending),
        .status_byte(status_byte), .event_status(event_status),
        .event_enable_mask(event_enable_mask), .err_queue_clear(err_queue_clear),
        .other_cmd(other_cmd), .other_cmd_stb(other_cmd_stb),
        .sub_hdr_stb(sub_hdr_stb), .sub_level(sub_level));
    ser_host_model u_ser_host_model (.clk(clk), .cmd_in(cmd_in), .cmd_ready(cmd_ready),
        .rsp_out(rsp_out), .rsp_ready(rsp_ready));
    // Strobes are one cycle wide, so count them as they pass
    always @(posedge clk) begin
        if (err_queue_clear === 1'b1) clr_cnt++;
        if (other_cmd_stb === 1'b1) oth_cnt++;
        if (sub_hdr_stb === 1'b1) begin
            sub_cnt++;
            lvl = sub_level;
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic stop_test;
        $display("Mismatches %0d, comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic cmd(input string s);
        bit ok;
        int w;
        u_ser_host_model.send(s, ok);
        @(negedge clk);
        for (w = 0; w < 300 && cmd_ready !== 1'b1; w++) @(negedge clk);
        check(ok && cmd_ready === 1'b1, 1, "command not accepted");
        if (!ok || cmd_ready !== 1'b1) stop_test();
        repeat (3) @(posedge clk);
    endtask
    task automatic ask(input string s, input string exp);
        int w;
        u_ser_host_model.rq.delete();
        u_ser_host_model.last_cnt = 0;
        cmd(s);
        for (w = 0; w < 500 && u_ser_host_model.last_cnt == 0; w++) @(posedge clk);
        check(u_ser_host_model.rq.size(), exp.len(), "reply length");
        if (u_ser_host_model.last_cnt == 0) begin
            mismatches++;
            $display("ERROR %0t: reply timed out", $time);
            stop_test();
        end
        for (int i = 0; i < exp.len() && i < u_ser_host_model.rq.size(); i++)
            check(u_ser_host_model.rq[i], exp[i], "reply byte");
        repeat (3) @(posedge clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_enable;
        check(event_status, 8'h80, "power-on events");
        check(event_enable_mask, 16'h0000, "mask reset");
        foreach (forms[i]) begin
            cmd("*ESE 0\n");
            cmd(forms[i]);
            check(event_enable_mask, 16'h0020, "mask from numeric form");
        end
        check(status_byte, 8'h00, "summary masked off");
        u_ser_host_model.slow = 1'b1;
        ask("*ESE?\n", "32\n");
        u_ser_host_model.slow = 1'b0;
    endtask
    task automatic t_summary;
        cmd("*ESE 128\n");
        check(status_byte, 8'h20, "summary from power-on bit");
        cmd("*ESE 65535\n");
        check(event_enable_mask, 16'hFFFF, "full mask width");
        ask("*ESE?\n", "65535\n");
        cmd("*ESE 127\n");
        check(status_byte, 8'h00, "zero bit masks event");
    endtask
    task automatic t_events;
        ev_dev_err <= 1'b1;
        ev_exe_err <= 1'b1;
        @(posedge clk);
        ev_dev_err <= 1'b0;
        ev_exe_err <= 1'b0;
        repeat (3) @(posedge clk);
        check(event_status, 8'h98, "error events");
        cmd("*XYZ\n");
        check(event_status, 8'hB8, "command error bit");
        check(status_byte, 8'h20, "summary from errors");
        ask("*ESR?\n", "184\n");
        check(event_status, 8'h00, "events read and cleared");
    endtask
    task automatic t_clear;
        cmd("*CLS?\n");
        check(event_status, 8'h20, "clear query refused");
        check(clr_cnt, 0, "refused clear left queue");
        ops_pending <= 1'b1;
        cmd("*OPC\n");
        check(event_status[0], 1'b0, "operation still pending");
        cmd("*CLS\n");
        check({status_byte, event_status}, 16'h0000, "status cleared");
        check(clr_cnt, 1, "error queue emptied");
        check(event_enable_mask, 16'h007F, "mask kept");
        ops_pending <= 1'b0;
        repeat (4) @(posedge clk);
        check(event_status, 8'h00, "monitoring stopped");
        cmd("*OPC\n");
        check(event_status, 8'h01, "operation complete");
    endtask
    task automatic t_headers;
        cmd("*RST\n");
        check(oth_cnt, 1, "reset forwarded");
        cmd(":ROUT:BIAS:PORT\n");
        check({sub_cnt[3:0], lvl}, 16'h0013, "short form depth");
        cmd(":ROUTe:BIAS:PORT\n");
        check({sub_cnt[3:0], lvl}, 16'h0023, "long form depth");
        cmd("ESE 64\n");
        check(sub_cnt, 3, "no asterisk is subsystem");
        check(event_enable_mask, 16'h007F, "subsystem left mask");
        cmd("ROUT:BIAS:PORT\n");
        check({sub_cnt[3:0], lvl}, 16'h0043, "no leading colon depth");
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_enable();
        t_summary();
        t_events();
        t_clear();
        t_headers();
        stop_test();
    end
endmodule // tb_top
